//--- src/gpt_timer.sv
/*
 * General-purpose 16-bit timer with prescaler, auto-reload, up to four
 * capture/compare channels, encoder and hall inputs, link and ADC triggers.
 * Assumes a single 50 MHz clock, synchronous reset, a one-cycle register
 * port with read data one cycle later, and asynchronous pin inputs.
 */
// The placing of the registers and the address-and-strobe port are this design's own decisions.
// Overview of operation
// [RQ1] 16-bit counter counts up, down or up/down.
// [RQ2] Prescaler divides by any value 1 to 65536.
// [RQ3] Four or two capture/compare channels, mode selectable.
// [RQ4] One-pulse mode gives a single output pulse.
// [RQ5] Only the four-channel instance raises DMA requests.
// [RQ6] Four-channel instance counts quadrature encoder position.
// [RQ7] Four-channel instance handles one to three hall sensors.
// [RQ8] Instances link to synchronise or chain events.
// [RQ9] Counter freezes during debug halt when selected.
// [RQ10] Two-channel instance can run from low-speed clock.
// [RQ11] Timer events trigger ADC conversions.
// [RQ12] Reload on overflow or underflow, flag update.
// [RQ13] PWM output changes on match, restores on reload.
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defs.svh"

module gpt_timer
   import gpt_pkg::*;
#(
   parameter int NUM_CH = 4,
   parameter bit HAS_DMA = 1'b1,
   parameter bit HAS_QUAD = 1'b1,
   parameter bit HAS_LSE = 1'b0
) (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic srst_i,
   // Register port.
   input wire logic [7:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [15:0] reg_rdata_o,
   // Pins and system inputs.
   input wire logic [NUM_CH-1:0] ch_in_i,
   input wire logic low_speed_external_clock_i,
   input wire logic dbg_halt_i,
   input wire logic link_trig_i,
   // Outputs.
   output logic [NUM_CH-1:0] ch_out_o,
   output logic irq_o,
   output logic dma_req_o,
   output logic link_trgo_o,
   output logic adc_trig_o
);

   localparam int MAXCH = 4;

   gpt_ctrl_t ctrl_q;
   logic [15:0] psc_q, psc_cnt_q, arr_q, cnt_q, cnt_d;
   logic [7:0] ccmode_q;
   logic [15:0] ccr_q [MAXCH];
   logic [`GPT_STS_W-1:0] sts_q, ien_q, dmaen_q, ev;
   logic [MAXCH-1:0] armed_q, cap_ev, match;
   logic [NUM_CH-1:0] ch_s1_q, ch_s2_q, ch_s3_q, out_q;
   logic [MAXCH-1:0] cin, cin_old;
   logic lse_s1_q, lse_s2_q, lse_s3_q;
   logic cdown_q, upd_ev, tick, run, src_ev, step, step_up;
   logic enc_step, enc_up, hall_q, hall_ev, link_rst_ev;
   logic irq_q, dma_q, trgo_q, adc_q;
   logic [15:0] rdata_q;

   // Address decode for the channel compare registers.
   function automatic logic is_ccr(input logic [7:0] a);
      return (a >= `GPT_OFF_CCR0) && (a <= `GPT_OFF_CCR3) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic [1:0] ccr_idx(input logic [7:0] a);
      return a[3:2];
   endfunction

   function automatic gpt_chmode_t ch_mode(input int i, input logic [7:0] m);
      return gpt_chmode_t'(m[2*i +: 2]);
   endfunction

   // Pin synchronisers; the third stage only feeds edge detection.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ch_s1_q <= '0;
         ch_s2_q <= '0;
         ch_s3_q <= '0;
         lse_s1_q <= 1'b0;
         lse_s2_q <= 1'b0;
         lse_s3_q <= 1'b0;
      end else begin
         ch_s1_q <= ch_in_i;
         ch_s2_q <= ch_s1_q;
         ch_s3_q <= ch_s2_q;
         lse_s1_q <= low_speed_external_clock_i;
         lse_s2_q <= lse_s1_q;
         lse_s3_q <= lse_s2_q;
      end
   end

   // Widen channel inputs to four lanes so unused lanes read as zero.
   always_comb begin
      cin = '0;
      cin_old = '0;
      cin[NUM_CH-1:0] = ch_s2_q;
      cin_old[NUM_CH-1:0] = ch_s3_q;
   end

   // Clock source, freeze and encoder/hall decode.
   always_comb begin
      run = ctrl_q.en && !(ctrl_q.freeze && dbg_halt_i); // [RQ9]
      unique case (ctrl_q.clk_src)
         GPT_SRC_INT: src_ev = 1'b1;
         GPT_SRC_LSE: src_ev = HAS_LSE && lse_s2_q && !lse_s3_q; // [RQ10]
         GPT_SRC_LINK: src_ev = link_trig_i; // [RQ8]
         default: src_ev = 1'b0;
      endcase
      tick = run && src_ev && (psc_cnt_q >= psc_q); // [RQ2]
      enc_step = HAS_QUAD && ctrl_q.enc_en && run &&
         ((cin[0] ^ cin_old[0]) || (cin[1] ^ cin_old[1])); // [RQ6]
      // An edge on A counts up when A differs from B; on B the reverse.
      enc_up = (cin[0] ^ cin_old[0]) ? (cin[0] != cin[1])
                                     : (cin[0] == cin[1]);
      hall_ev = HAS_QUAD && ctrl_q.hall_en &&
         ((^cin[2:0]) != hall_q); // [RQ7]
      link_rst_ev = ctrl_q.link_rst && link_trig_i; // [RQ8]
   end

   // Prescaler counts source events up to the programmed value, dividing by one more.
   // A count left above a lowered divisor restarts at once, not at 65535.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         psc_cnt_q <= 16'h0000;
      end else if (run && src_ev) begin
         psc_cnt_q <= (psc_cnt_q >= psc_q) ? 16'h0000 : psc_cnt_q + 16'h0001;
      end
   end

   // Next counter value with reload at both ends.
   always_comb begin
      cnt_d = cnt_q;
      upd_ev = 1'b0;
      step = 1'b0;
      step_up = !cdown_q;
      if (ctrl_q.enc_en && HAS_QUAD) begin
         step = enc_step;
         step_up = enc_up;
      end else if (tick) begin
         step = 1'b1;
         unique case (ctrl_q.dir_mode)
            GPT_DIR_UP: step_up = 1'b1;
            GPT_DIR_DOWN: step_up = 1'b0;
            default: step_up = !cdown_q;
         endcase
      end
      if (step) begin
         if (step_up && cnt_q >= arr_q) begin
            upd_ev = 1'b1; // [RQ12]
            if (ctrl_q.dir_mode == GPT_DIR_CENTER && !ctrl_q.enc_en) begin
               cnt_d = (arr_q == 16'h0000) ? 16'h0000 : arr_q - 16'h0001;
            end else begin
               cnt_d = 16'h0000;
            end
         end else if (!step_up && cnt_q == 16'h0000) begin
            upd_ev = 1'b1; // [RQ12]
            if (ctrl_q.dir_mode == GPT_DIR_CENTER && !ctrl_q.enc_en) begin
               cnt_d = (arr_q == 16'h0000) ? 16'h0000 : 16'h0001;
            end else begin
               cnt_d = arr_q;
            end
         end else begin
            cnt_d = step_up ? cnt_q + 16'h0001 : cnt_q - 16'h0001; // [RQ1]
         end
      end
   end

   // Counter register; software writes and resets take priority.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         cnt_q <= 16'h0000;
         cdown_q <= 1'b0;
         hall_q <= 1'b0;
      end else begin
         hall_q <= ^cin[2:0];
         if (reg_wr_i && reg_addr_i == `GPT_OFF_CNT) begin
            cnt_q <= reg_wdata_i;
         end else if (link_rst_ev || hall_ev) begin
            cnt_q <= 16'h0000; // [RQ8] [RQ7]
         end else begin
            cnt_q <= cnt_d; // [RQ1]
            if (upd_ev && ctrl_q.dir_mode == GPT_DIR_CENTER) begin
               cdown_q <= step_up;
            end else if (ctrl_q.dir_mode != GPT_DIR_CENTER) begin
               cdown_q <= 1'b0;
            end
         end
      end
   end

   // Compare matches on counter steps and capture edges per channel.
   always_comb begin
      match = '0;
      cap_ev = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         match[i] = step && (cnt_d == ccr_q[i]) &&
            (ch_mode(i, ccmode_q) != GPT_CH_CAPTURE);
         cap_ev[i] = (ch_mode(i, ccmode_q) == GPT_CH_CAPTURE) &&
            !(ctrl_q.enc_en && i < 2) && cin[i] && !cin_old[i]; // [RQ3]
      end
      if (hall_ev) begin
         cap_ev[0] = 1'b1;
      end
   end

   // Control and configuration registers written by software.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         ctrl_q <= `GPT_RST_CTRL;
         psc_q <= `GPT_RST_PSC;
         arr_q <= `GPT_RST_ARR;
         ccmode_q <= 8'h00;
         ien_q <= '0;
         dmaen_q <= '0;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            `GPT_OFF_CTRL: ctrl_q <= reg_wdata_i;
            `GPT_OFF_PSC: psc_q <= reg_wdata_i;
            `GPT_OFF_ARR: arr_q <= reg_wdata_i;
            `GPT_OFF_CCMODE: ccmode_q <= reg_wdata_i[7:0];
            `GPT_OFF_IEN: ien_q <= reg_wdata_i[`GPT_STS_W-1:0];
            `GPT_OFF_DMAEN: dmaen_q <= reg_wdata_i[`GPT_STS_W-1:0];
            default: ;
         endcase
      end else if (upd_ev && ctrl_q.opm && !ctrl_q.enc_en) begin
         ctrl_q.en <= 1'b0; // [RQ4]
      end
   end

   // Compare registers: software writes, hardware captures win.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         for (int i = 0; i < MAXCH; i++) begin
            ccr_q[i] <= 16'h0000;
         end
      end else begin
         for (int i = 0; i < MAXCH; i++) begin
            if (cap_ev[i]) begin
               ccr_q[i] <= cnt_q; // [RQ3]
            end else if (reg_wr_i && is_ccr(reg_addr_i) &&
                         ccr_idx(reg_addr_i) == 2'(i)) begin
               ccr_q[i] <= reg_wdata_i;
            end
         end
      end
   end

   // Channel outputs per mode.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         out_q <= '0;
         armed_q <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            unique case (ch_mode(i, ccmode_q))
               GPT_CH_COMPARE: begin
                  if (match[i]) begin
                     out_q[i] <= !out_q[i];
                  end
               end
               GPT_CH_PWM: begin
                  if (match[i]) begin
                     out_q[i] <= 1'b0; // [RQ13]
                  end else if (upd_ev) begin
                     out_q[i] <= 1'b1; // [RQ13]
                  end
               end
               GPT_CH_ONEPULSE: begin
                  if (upd_ev && out_q[i]) begin
                     out_q[i] <= 1'b0; // [RQ4]
                     armed_q[i] <= 1'b0;
                  end else if (match[i] && armed_q[i]) begin
                     out_q[i] <= 1'b1; // [RQ4]
                  end
               end
               default: out_q[i] <= 1'b0;
            endcase
         end
         // Writing the mode register arms every one-pulse channel again.
         if (reg_wr_i && reg_addr_i == `GPT_OFF_CCMODE) begin
            armed_q <= '1;
         end
      end
   end

   // Event vector feeding status and DMA, with the link trigger input as its top bit.
   always_comb begin
      ev = '0;
      ev[`GPT_STS_UPD] = upd_ev;
      ev[`GPT_STS_CC0 +: MAXCH] = match | cap_ev;
      ev[`GPT_STS_TRG] = link_trig_i;
   end

   // Sticky status; an event in the clearing cycle is kept.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         sts_q <= '0;
      end else if (reg_wr_i && reg_addr_i == `GPT_OFF_ICLR) begin
         sts_q <= (sts_q & ~reg_wdata_i[`GPT_STS_W-1:0]) | ev;
      end else begin
         sts_q <= sts_q | ev;
      end
   end

   // Registered interrupt, DMA, link and ADC trigger outputs.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         irq_q <= 1'b0;
         dma_q <= 1'b0;
         trgo_q <= 1'b0;
         adc_q <= 1'b0;
      end else begin
         irq_q <= |(sts_q & ien_q);
         dma_q <= HAS_DMA && |(ev & dmaen_q); // [RQ5]
         trgo_q <= upd_ev; // [RQ8]
         adc_q <= upd_ev || match[0]; // [RQ11]
      end
   end

   // Read data one cycle after the read strobe; unmapped reads give zero.
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rdata_q <= 16'h0000;
      end else if (reg_rd_i) begin
         if (is_ccr(reg_addr_i)) begin
            rdata_q <= ccr_q[ccr_idx(reg_addr_i)];
         end else begin
            unique case (reg_addr_i)
               `GPT_OFF_CTRL: rdata_q <= ctrl_q;
               `GPT_OFF_PSC: rdata_q <= psc_q;
               `GPT_OFF_ARR: rdata_q <= arr_q;
               `GPT_OFF_CNT: rdata_q <= cnt_q;
               `GPT_OFF_CCMODE: rdata_q <= {8'h00, ccmode_q};
               `GPT_OFF_STS: rdata_q <= {10'h000, sts_q};
               `GPT_OFF_IEN: rdata_q <= {10'h000, ien_q};
               `GPT_OFF_DMAEN: rdata_q <= {10'h000, dmaen_q};
               default: rdata_q <= 16'h0000;
            endcase
         end
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign ch_out_o = out_q;
   assign irq_o = irq_q;
   assign dma_req_o = dma_q;
   assign link_trgo_o = trgo_q;
   assign adc_trig_o = adc_q;

   // Checks tied to the clock and reset of the single domain.
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);

   sequence up_at_top_s;
      tick && !ctrl_q.enc_en && ctrl_q.dir_mode == GPT_DIR_UP &&
         cnt_q == arr_q;
   endsequence

   sequence quiet_write_s;
      !(reg_wr_i && reg_addr_i == `GPT_OFF_CNT) && !link_rst_ev && !hall_ev;
   endsequence

   up_reload_a: assert property ( // [RQ12]
      up_at_top_s and quiet_write_s |=> cnt_q == 16'h0000 && link_trgo_o)
      else $error("Counter did not reload at the top.");

   down_reload_a: assert property ( // [RQ1]
      tick && !ctrl_q.enc_en && ctrl_q.dir_mode == GPT_DIR_DOWN &&
      cnt_q == 16'h0000 and quiet_write_s |=> cnt_q == $past(arr_q))
      else $error("Down counter did not reload from auto-reload.");

   psc_spacing_a: assert property ( // [RQ2]
      tick && psc_q == 16'h0003 && ctrl_q.clk_src == GPT_SRC_INT &&
      !ctrl_q.freeze && $stable(psc_q) |=> !tick [*3])
      else $error("Prescaler ticked early.");

   freeze_hold_a: assert property ( // [RQ9]
      ctrl_q.freeze && dbg_halt_i and quiet_write_s |=> $stable(cnt_q))
      else $error("Counter moved during debug halt.");

   pwm_level_a: assert property ( // [RQ13]
      ch_mode(0, ccmode_q) == GPT_CH_PWM && match[0] |=> !ch_out_o[0])
      else $error("PWM output not cleared on match.");

   onepulse_stop_a: assert property ( // [RQ4]
      upd_ev && ctrl_q.opm && !ctrl_q.enc_en && !reg_wr_i |=> !ctrl_q.en)
      else $error("One-pulse counter kept running.");

   capture_value_a: assert property ( // [RQ3]
      cap_ev[3] |=> ccr_q[3] == $past(cnt_q))
      else $error("Capture did not store the counter.");

   dma_gate_a: assert property ( // [RQ5]
      dma_req_o |-> HAS_DMA && $past(|(ev & dmaen_q)))
      else $error("DMA request from an instance without DMA.");

   adc_trigger_a: assert property ( // [RQ11]
      upd_ev |=> adc_trig_o ##1 (adc_trig_o == $past(upd_ev || match[0])))
      else $error("ADC trigger missed an update.");

   link_reset_a: assert property ( // [RQ8]
      link_rst_ev && !(reg_wr_i && reg_addr_i == `GPT_OFF_CNT)
      |=> cnt_q == 16'h0000)
      else $error("Link trigger did not reset the counter.");

   encoder_count_a: assert property ( // [RQ6]
      enc_step && enc_up && cnt_q < arr_q and quiet_write_s
      |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("Encoder step not counted up.");

   hall_capture_a: assert property ( // [RQ7]
      hall_ev && !(reg_wr_i && reg_addr_i == `GPT_OFF_CNT)
      |=> cnt_q == 16'h0000 && ccr_q[0] == $past(cnt_q))
      else $error("Hall edge did not capture and restart.");

   lse_gate_a: assert property ( // [RQ10]
      ctrl_q.clk_src == GPT_SRC_LSE && !(lse_s2_q && !lse_s3_q) |-> !tick)
      else $error("Low-speed source ticked without an edge.");

endmodule
`default_nettype wire

//--- src/gpt_defs.svh
/*
 * Register offsets, field positions, reset values and fixed figures of the
 * general-purpose timer. Assumes it is included by bare name after the
 * package, in files that switch implicit nets off themselves.
 */
`ifndef GPT_DEFS_SVH
`define GPT_DEFS_SVH

// Register byte offsets on the plain register port.
`define GPT_OFF_CTRL   8'h00
`define GPT_OFF_PSC    8'h04
`define GPT_OFF_ARR    8'h08
`define GPT_OFF_CNT    8'h0c
`define GPT_OFF_CCMODE 8'h10
`define GPT_OFF_STS    8'h14
`define GPT_OFF_ICLR   8'h18
`define GPT_OFF_IEN    8'h1c
`define GPT_OFF_DMAEN  8'h20
`define GPT_OFF_CCR0   8'h30
`define GPT_OFF_CCR3   8'h3c

// Status layout: update, four channel events, link trigger.
`define GPT_STS_UPD    0
`define GPT_STS_CC0    1
`define GPT_STS_TRG    5
`define GPT_STS_W      6

// Reset values.
`define GPT_RST_CTRL   16'h0000
`define GPT_RST_PSC    16'h0000
`define GPT_RST_ARR    16'hffff

// Low-speed external clock rate, for reference by software.
`define GPT_LSE_HZ     32768

`endif

//--- src/gpt_pkg.sv
/*
 * Types of the general-purpose timer: counting modes, channel modes,
 * clock sources and the packed control register.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gpt_pkg;

   typedef enum logic [1:0] {
      GPT_DIR_UP = 2'b00,
      GPT_DIR_DOWN = 2'b01,
      GPT_DIR_CENTER = 2'b10,
      GPT_DIR_RSVD = 2'b11
   } gpt_dir_t;

   typedef enum logic [1:0] {
      GPT_CH_CAPTURE = 2'b00,
      GPT_CH_COMPARE = 2'b01,
      GPT_CH_PWM = 2'b10,
      GPT_CH_ONEPULSE = 2'b11
   } gpt_chmode_t;

   typedef enum logic [1:0] {
      GPT_SRC_INT = 2'b00,
      GPT_SRC_LSE = 2'b01,
      GPT_SRC_LINK = 2'b10,
      GPT_SRC_RSVD = 2'b11
   } gpt_src_t;

   // Control register, bit 0 at the bottom.
   typedef struct packed {
      logic [4:0] rsvd_hi;
      logic hall_en;
      logic enc_en;
      logic link_rst;
      gpt_src_t clk_src;
      logic freeze;
      logic opm;
      gpt_dir_t dir_mode;
      logic rsvd_lo;
      logic en;
   } gpt_ctrl_t;

endpackage

//--- verification/gpt_far_side.sv
/*
 * Far-side model of the timer pins: a quadrature encoder on channels 0 and 1,
 * which doubles as a hall sensor line, and a capture source on channel 3.
 * Assumes one-cycle step and capture requests from the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module gpt_far_side (
   // Clock.
   input wire logic clock_i,
   // Requests from the bench.
   input wire logic step_i,
   input wire logic back_i,
   input wire logic cap_i,
   // Pins toward the timer.
   output logic [3:0] pins_o
);
   logic [1:0] phase_q = 2'd0;
   logic [2:0] cap_q = 3'd0;
   // Phase walks one step per request, so only one line moves at a time.
   always_ff @(posedge clock_i) begin
      if (step_i) begin
         phase_q <= back_i ? phase_q - 2'd1 : phase_q + 2'd1;
      end
   end
   // The capture line stays high long enough to pass the synchroniser.
   always_ff @(posedge clock_i) begin
      cap_q <= cap_i ? 3'd4 : (cap_q != 3'd0 ? cap_q - 3'd1 : 3'd0);
   end
   // Gray code: line A on channel 0 leads line B on channel 1 going forward.
   assign pins_o = {cap_q != 3'd0, 1'b0, phase_q[1], ^phase_q};
endmodule
`default_nettype wire

//--- verification/general_purpose_timer_bench.sv
/*
 * Self-checking bench of the four-channel timer: register reads and writes,
 * counting modes, channel outputs, interrupt, encoder, hall and link inputs.
 * Assumes the design files and the far-side pin model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defs.svh"
module general_purpose_timer_bench;
   logic clock_i;
   logic srst_i;
   logic [7:0] reg_addr_i;
   logic [15:0] reg_wdata_i;
   logic reg_wr_i;
   logic reg_rd_i;
   logic [15:0] reg_rdata_o;
   logic [3:0] ch_in_i;
   logic dbg_halt_i;
   logic link_trig_i;
   logic [3:0] ch_out_o;
   logic irq_o, dma_req_o, link_trgo_o, adc_trig_o;
   logic lse_r, dma2;
   logic [15:0] rdata2, d2;
   logic step_r, back_r, cap_r;
   logic [3:0] prev_q;
   logic [15:0] d;
   int num_errors, check_count, n_upd, n_adc, n_dma, n_hi0, n_r1, n_r2;
   int n_dma2;

   gpt_timer u_gpt_timer (.clock_i(clock_i), .srst_i(srst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .ch_in_i(ch_in_i), .low_speed_external_clock_i(lse_r),
      .dbg_halt_i(dbg_halt_i), .link_trig_i(link_trig_i),
      .ch_out_o(ch_out_o), .irq_o(irq_o), .dma_req_o(dma_req_o),
      .link_trgo_o(link_trgo_o), .adc_trig_o(adc_trig_o));
   // Two-channel instance on the same register port, low-speed source on.
   gpt_timer #(.NUM_CH(2), .HAS_DMA(1'b0), .HAS_QUAD(1'b0), .HAS_LSE(1'b1))
   u_gpt_timer_2ch (.clock_i(clock_i), .srst_i(srst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata2),
      .ch_in_i(ch_in_i[1:0]), .low_speed_external_clock_i(lse_r),
      .dbg_halt_i(dbg_halt_i), .link_trig_i(link_trig_i),
      .ch_out_o(), .irq_o(), .dma_req_o(dma2),
      .link_trgo_o(), .adc_trig_o());
   gpt_far_side u_gpt_far_side (.clock_i(clock_i), .step_i(step_r),
      .back_i(back_r), .cap_i(cap_r), .pins_o(ch_in_i));

   // Free-running 50 MHz clock.
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   // Pulse and level tallies, sampled before each edge's updates land.
   always @(posedge clock_i) begin
      n_upd += int'(link_trgo_o === 1'b1);
      n_adc += int'(adc_trig_o === 1'b1);
      n_dma += int'(dma_req_o === 1'b1);
      n_dma2 += int'(dma2 === 1'b1);
      n_hi0 += int'(ch_out_o[0] === 1'b1);
      n_r1 += int'(ch_out_o[1] === 1'b1 && prev_q[1] !== 1'b1);
      n_r2 += int'(ch_out_o[2] === 1'b1 && prev_q[2] !== 1'b1);
      prev_q = ch_out_o;
   end

   task automatic test_done;
      $display("TB: errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // One-cycle write strobe beside address and data.
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask

   // One-cycle read strobe; data is taken in the following cycle only.
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
      d2 = rdata2;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("unexpected at %0t: read %h wanted %h", $time, got, exp);
         num_errors++;
      end
   endtask

   task automatic rng(input logic [15:0] got, input int lo, input int hi);
      check_count++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         $display("unexpected at %0t: %h not in %0d..%0d", $time, got, lo, hi);
         num_errors++;
      end
   endtask

   // Clears the counter and all tallies but n_dma2, runs with the given control word.
   task automatic run(input logic [15:0] ctrl, input int cyc);
      wr(`GPT_OFF_CNT, 16'h0000);
      @(negedge clock_i);
      {n_upd, n_adc, n_dma, n_hi0, n_r1, n_r2} = '0;
      wr(`GPT_OFF_CTRL, ctrl);
      repeat (cyc) @(posedge clock_i);
      wr(`GPT_OFF_CTRL, 16'h0000);
      repeat (3) @(posedge clock_i);
   endtask

   // Moves the encoder n steps, slowly enough for the synchroniser.
   task automatic enc(input logic bk, input int n);
      repeat (n) begin
         @(posedge clock_i);
         step_r <= 1'b1;
         back_r <= bk;
         @(posedge clock_i);
         step_r <= 1'b0;
         repeat (6) @(posedge clock_i);
      end
   endtask

   // Single-cycle pulses from the other timer.
   task automatic lnk(input int n);
      repeat (n) begin
         @(posedge clock_i);
         link_trig_i <= 1'b1;
         @(posedge clock_i);
         link_trig_i <= 1'b0;
         repeat (3) @(posedge clock_i);
      end
   endtask

   // Hang guard, far beyond the length of the sequence below.
   initial begin
      repeat (20000) @(posedge clock_i);
      num_errors++;
      test_done();
   end

   initial begin
      {srst_i, reg_wr_i, reg_rd_i, dbg_halt_i, link_trig_i} = 5'b10000;
      {reg_addr_i, reg_wdata_i, step_r, back_r, cap_r, lse_r} = '0;
      prev_q = '0;
      {num_errors, check_count} = '0;
      repeat (10) @(posedge clock_i);
      srst_i <= 1'b0;
      @(posedge clock_i);
      // Reset values, and an unmapped address reading zero.
      rd(`GPT_OFF_CTRL, d); chk(d, `GPT_RST_CTRL);
      rd(`GPT_OFF_PSC, d); chk(d, `GPT_RST_PSC);
      rd(`GPT_OFF_ARR, d); chk(d, `GPT_RST_ARR);
      rd(8'h40, d); chk(d, 16'h0000);
      // Up counting, undivided, with update DMA and ADC triggers.
      wr(`GPT_OFF_ARR, 16'h0002);
      wr(`GPT_OFF_DMAEN, 16'h0001);
      run(16'h0001, 30);
      rng(n_upd, 9, 11);
      chk(n_dma, n_upd);
      chk(n_adc, n_upd);
      rd(`GPT_OFF_CNT, d); rng(d, 0, 2);
      // One-pulse counting stops itself at the first update.
      wr(`GPT_OFF_CNT, 16'h0000);
      wr(`GPT_OFF_CTRL, 16'h0011);
      repeat (8) @(posedge clock_i);
      rd(`GPT_OFF_CTRL, d); chk(d, 16'h0010);
      // Down counting, DMA now off.
      wr(`GPT_OFF_DMAEN, 16'h0000);
      run(16'h0005, 30);
      rng(n_upd, 9, 11);
      chk(n_dma, 0);
      // Divide by four, period of five ticks.
      wr(`GPT_OFF_PSC, 16'h0003);
      wr(`GPT_OFF_ARR, 16'h0004);
      run(16'h0001, 200);
      rng(n_upd, 9, 11);
      // Up/down counting updates at both ends.
      wr(`GPT_OFF_PSC, 16'h0000);
      run(16'h0009, 80);
      rng(n_upd, 19, 21);
      // PWM on ch0, one-pulse on ch1, toggle on ch2, capture on ch3.
      wr(`GPT_OFF_CCR0, 16'h0002);
      wr(8'h34, 16'h0003);
      wr(8'h38, 16'h0001);
      wr(`GPT_OFF_CCMODE, 16'h001e);
      run(16'h0001, 100);
      rng(n_hi0, 36, 44);
      chk(n_r1, 1);
      rng(n_r2, 10, 12);
      // Sticky status, masked then enabled interrupt, then cleared.
      rd(`GPT_OFF_STS, d); chk(d[0], 1'b1);
      chk(irq_o, 1'b0);
      wr(`GPT_OFF_IEN, 16'h0001);
      repeat (3) @(negedge clock_i);
      chk(irq_o, 1'b1);
      wr(`GPT_OFF_ICLR, 16'h003f);
      repeat (3) @(negedge clock_i);
      chk(irq_o, 1'b0);
      rd(`GPT_OFF_STS, d); chk(d, 16'h0000);
      // Debug freeze holds the count; capture stores it.
      wr(`GPT_OFF_ARR, 16'hffff);
      dbg_halt_i <= 1'b1;
      wr(`GPT_OFF_CNT, 16'h0007);
      wr(`GPT_OFF_CTRL, 16'h0021);
      repeat (20) @(posedge clock_i);
      rd(`GPT_OFF_CNT, d); chk(d, 16'h0007);
      cap_r <= 1'b1;
      @(posedge clock_i);
      cap_r <= 1'b0;
      repeat (12) @(posedge clock_i);
      rd(`GPT_OFF_CCR3, d); chk(d, 16'h0007);
      rd(`GPT_OFF_STS, d); chk(d[4], 1'b1);
      dbg_halt_i <= 1'b0;
      repeat (20) @(posedge clock_i);
      rd(`GPT_OFF_CNT, d); rng(d, 8, 40);
      // Encoder counts each edge, up going forward, down going back.
      wr(`GPT_OFF_CTRL, 16'h0000);
      wr(`GPT_OFF_CNT, 16'h0000);
      wr(`GPT_OFF_CTRL, 16'h0201);
      enc(1'b0, 8);
      rd(`GPT_OFF_CNT, d); chk(d, 16'h0008);
      enc(1'b1, 3);
      rd(`GPT_OFF_CNT, d); chk(d, 16'h0005);
      // Hall edge captures the count into CCR0 and restarts it.
      wr(`GPT_OFF_CTRL, 16'h0000);
      wr(`GPT_OFF_ICLR, 16'h003f);
      wr(`GPT_OFF_CNT, 16'h0000);
      wr(`GPT_OFF_CTRL, 16'h0401);
      repeat (30) @(posedge clock_i);
      enc(1'b0, 1);
      rd(`GPT_OFF_STS, d); chk(d[1], 1'b1);
      rd(`GPT_OFF_CCR0, d); rng(d, 25, 60);
      rd(`GPT_OFF_CNT, d); rng(d, 0, 20);
      // Chained clock from the other timer, then reset on its trigger.
      wr(`GPT_OFF_CTRL, 16'h0000);
      wr(`GPT_OFF_CNT, 16'h0000);
      wr(`GPT_OFF_CTRL, 16'h0081);
      lnk(5);
      rd(`GPT_OFF_CNT, d); chk(d, 16'h0005);
      rd(`GPT_OFF_STS, d); chk(d[5], 1'b1);
      wr(`GPT_OFF_CTRL, 16'h0181);
      lnk(1);
      rd(`GPT_OFF_CNT, d); chk(d, 16'h0000);
      // Low-speed source: only the two-channel timer counts its rising edges.
      wr(`GPT_OFF_CTRL, 16'h0000);
      wr(`GPT_OFF_CNT, 16'h0000);
      wr(`GPT_OFF_CTRL, 16'h0041);
      repeat (8) begin
         repeat (4) @(posedge clock_i);
         lse_r <= ~lse_r;
      end
      repeat (4) @(posedge clock_i);
      rd(`GPT_OFF_CNT, d); chk(d, 16'h0000);
      chk(d2, 16'h0004);
      chk(n_dma2, 0);
      test_done();
   end
endmodule
`default_nettype wire
